// ==== hostport_pkg.sv ====
package hostport_pkg;
  localparam int DATA_W = 8;
  localparam int MEM_DEPTH = 256;
  localparam int CLK_PERIOD_NS = 5;
  // Device reset hold and post-reset quiet time, in device clocks
  localparam int RESET_HOLD_CLKS = 16;
  localparam int RESET_QUIET_CLKS = 16;
  // Strobe pulse and spacing minimums
  localparam int STROBE_MIN_NS = 65;
  localparam int SPACING_MIN_NS = 85;
  localparam int STROBE_CYCLES = (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SPACING_CYCLES = (SPACING_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Internal location map of the device end
  localparam logic [7:0] ROLE_ADDR = 8'h05;
  localparam int ROLE_BIT = 0;
  localparam logic [7:0] IRQ_STATUS_ADDR = 8'h0D;
  localparam logic [7:0] IRQ_ENABLE_ADDR = 8'h06;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [4:0] CNT_ZERO = 5'h00;
endpackage : hostport_pkg

// ==== hostport_if.sv ====
interface hostport_if;
  logic chip_sel_low;
  logic read_strobe_low;
  logic write_strobe_low;
  logic pointer_or_data_select;
  logic reset_in_low;
  logic role_pin;
  logic irq_out;
  logic [7:0] host_data_out;
  logic host_data_oe_low;
  logic [7:0] dev_data_out;
  logic dev_data_oe_low;
  logic [7:0] data_bus;
  // Wire resolution: whichever end has its enable low drives the bus
  assign data_bus = !dev_data_oe_low ? dev_data_out :
                    (!host_data_oe_low ? host_data_out : 8'hFF);
  modport device (
    input chip_sel_low, read_strobe_low, write_strobe_low, pointer_or_data_select,
    input reset_in_low, role_pin, data_bus,
    output irq_out, dev_data_out, dev_data_oe_low
  );
  modport host (
    output chip_sel_low, read_strobe_low, write_strobe_low, pointer_or_data_select,
    output reset_in_low, role_pin, host_data_out, host_data_oe_low,
    input irq_out, data_bus
  );
endinterface : hostport_if

// ==== sync2.sv ====
module sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_reg <= INIT;
      q <= INIT;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule // sync2

// ==== hostport_device.sv ====
module hostport_device
  import hostport_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Processor port
  hostport_if.device bus,
  // Device-side events and state
  input wire logic [7:0] event_in,
  output logic role_peripheral,
  output logic in_reset
);
  logic [7:0] mem [MEM_DEPTH];
  logic cs_low_s, rd_low_s, wr_low_s, a0_s, rst_low_s, role_s;
  logic [7:0] data_s;
  logic wr_act_reg, rd_act_reg;
  logic [7:0] ptr_reg;
  logic [7:0] wdata_reg;
  logic a0_reg;
  logic [7:0] irq_stat_reg;
  logic [7:0] irq_en_reg;
  logic role_reg;
  logic [7:0] rdata_reg;
  logic wr_done, rd_start;
  logic wr_qual, rd_qual;

  // Pins are asynchronous to clock
  sync2 #(.W(6), .INIT(6'h3F)) u_sync_ctl ( // (R18)
    .clock(clock),
    .rst(rst),
    .d({bus.chip_sel_low, bus.read_strobe_low, bus.write_strobe_low,
        bus.pointer_or_data_select, bus.reset_in_low, bus.role_pin}),
    .q({cs_low_s, rd_low_s, wr_low_s, a0_s, rst_low_s, role_s})
  );
  sync2 #(.W(8)) u_sync_data (
    .clock(clock),
    .rst(rst),
    .d(bus.data_bus),
    .q(data_s)
  );

  assign wr_qual = !cs_low_s && !wr_low_s; // (R5)
  assign rd_qual = !cs_low_s && !rd_low_s; // (R6)
  assign in_reset = !rst_low_s;

  // A write completes when the qualified strobe rises; data is the last
  // value sampled while the strobe was low, covering the hold window
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_act_reg <= 1'b0;
      wdata_reg <= BYTE_ZERO;
      a0_reg <= 1'b0;
    end else begin
      wr_act_reg <= wr_qual;
      if (wr_qual) begin
        wdata_reg <= data_s;
        a0_reg <= a0_s;
      end
    end
  end
  assign wr_done = wr_act_reg && !wr_qual; // (R4)

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rd_act_reg <= 1'b0;
    end else begin
      rd_act_reg <= rd_qual;
    end
  end
  assign rd_start = rd_qual && !rd_act_reg;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ptr_reg <= BYTE_ZERO;
    end else if (!rst_low_s) begin
      ptr_reg <= BYTE_ZERO;
    end else if (wr_done && !a0_reg) begin
      ptr_reg <= wdata_reg; // (R1)
    end
  end

  // Plain storage; the special locations shadow their entries
  always_ff @(posedge clock) begin
    if (rst_low_s && wr_done && a0_reg) begin
      mem[ptr_reg] <= wdata_reg; // (R2)
    end
  end

  // Role is caught while external reset is held, then only software moves it
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      role_reg <= 1'b0;
    end else if (!rst_low_s) begin
      role_reg <= role_s; // (R13)
    end else if (wr_done && a0_reg && ptr_reg == ROLE_ADDR) begin
      role_reg <= wdata_reg[ROLE_BIT]; // (R15) (R16)
    end
  end
  assign role_peripheral = role_reg; // (R14)

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_en_reg <= BYTE_ZERO;
    end else if (!rst_low_s) begin
      irq_en_reg <= BYTE_ZERO;
    end else if (wr_done && a0_reg && ptr_reg == IRQ_ENABLE_ADDR) begin
      irq_en_reg <= wdata_reg;
    end
  end

  // Write-one-to-clear; a new event in the same cycle wins over the clear
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_stat_reg <= BYTE_ZERO;
    end else if (!rst_low_s) begin
      irq_stat_reg <= BYTE_ZERO;
    end else if (wr_done && a0_reg && ptr_reg == IRQ_STATUS_ADDR) begin
      irq_stat_reg <= (irq_stat_reg & ~wdata_reg) | (event_in & irq_en_reg); // (R9)
    end else begin
      irq_stat_reg <= irq_stat_reg | (event_in & irq_en_reg); // (R9)
    end
  end

  // Fixed active-high level, no polarity option
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bus.irq_out <= 1'b0;
    end else begin
      bus.irq_out <= |irq_stat_reg; // (R10)
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata_reg <= BYTE_ZERO;
    end else if (rd_start) begin
      case (ptr_reg)
        ROLE_ADDR: rdata_reg <= {7'h00, role_reg};
        IRQ_STATUS_ADDR: rdata_reg <= irq_stat_reg;
        IRQ_ENABLE_ADDR: rdata_reg <= irq_en_reg;
        default: rdata_reg <= mem[ptr_reg];
      endcase
    end
  end
  assign bus.dev_data_out = rdata_reg;
  // Drive only while cs and rd are both low at the pins; data settles
  // within three clocks, well inside the 65 ns access window
  assign bus.dev_data_oe_low = bus.chip_sel_low | bus.read_strobe_low; // (R7)
endmodule // hostport_device

// ==== hostport_host.sv ====
// Functional notes
// (R1) Selector low write loads address pointer
// (R2) Selector high write stores at pointer
// (R3) Host writes pointer before every read
// (R4) Write data captured at strobe rising edge
// (R5) Write strobe needs chip select
// (R6) Read strobe needs chip select
// (R7) Device drives bus only during read
// (R8) Sole device: chip select may stay low
// (R9) Interrupt high until software clears event
// (R10) Interrupt fixed active high
// (R11) Reset held low sixteen device clocks
// (R12) Sixteen clocks quiet after reset release
// (R13) Role pin sampled during external reset
// (R14) Role low host, high peripheral
// (R15) Role pin ignored outside reset
// (R16) Software may rewrite role bit
// (R17) Multiplexed bus latches selector externally
// (R18) Device synchronises strobes before acting; its bus drive enable decodes the raw cs and rd pins instead
module hostport_host
  import hostport_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Device port
  hostport_if.host bus,
  // User request
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [7:0] req_addr,
  input wire logic [7:0] req_wdata,
  input wire logic keep_cs_low,
  input wire logic role_strap,
  output logic req_ready,
  // User answer
  output logic resp_valid,
  output logic [7:0] resp_rdata,
  output logic irq_level
);
  typedef enum {ST_RESET, ST_QUIET, ST_IDLE, ST_PTR_LOW, ST_PTR_GAP,
                ST_ACC_LOW, ST_ACC_GAP} state_e;
  state_e state_reg;
  logic [4:0] cnt_reg;
  logic write_reg;
  logic [7:0] addr_reg, wdata_reg;
  logic irq_s;
  logic [7:0] data_s;
  logic cnt_done;

  // Hold includes the device's two-flop input delay plus margin; gap is the bare spacing minimum
  localparam logic [4:0] HOLD_LEN = 5'(STROBE_CYCLES + 4);
  localparam logic [4:0] GAP_LEN = 5'(SPACING_CYCLES);
  localparam logic [4:0] RST_LEN = 5'(RESET_HOLD_CLKS + 2);
  localparam logic [4:0] QUIET_LEN = 5'(RESET_QUIET_CLKS + 2);

  sync2 #(.W(9)) u_sync_in (
    .clock(clock),
    .rst(rst),
    .d({bus.irq_out, bus.data_bus}),
    .q({irq_s, data_s})
  );

  assign cnt_done = cnt_reg == CNT_ZERO;

  function automatic logic [4:0] dec(input logic [4:0] v);
    return (v == CNT_ZERO) ? CNT_ZERO : v - 5'h01;
  endfunction

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg <= ST_RESET;
      cnt_reg <= RST_LEN;
    end else begin
      cnt_reg <= dec(cnt_reg);
      case (state_reg)
        ST_RESET: if (cnt_done) begin // (R11)
          state_reg <= ST_QUIET;
          cnt_reg <= QUIET_LEN;
        end
        ST_QUIET: if (cnt_done) begin // (R12)
          state_reg <= ST_IDLE;
        end
        ST_IDLE: if (req_valid) begin
          state_reg <= ST_PTR_LOW; // (R3)
          cnt_reg <= HOLD_LEN;
        end
        ST_PTR_LOW: if (cnt_done) begin
          state_reg <= ST_PTR_GAP;
          cnt_reg <= GAP_LEN;
        end
        ST_PTR_GAP: if (cnt_done) begin
          state_reg <= ST_ACC_LOW;
          cnt_reg <= HOLD_LEN;
        end
        ST_ACC_LOW: if (cnt_done) begin
          state_reg <= ST_ACC_GAP;
          cnt_reg <= GAP_LEN;
        end
        ST_ACC_GAP: if (cnt_done) begin
          state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_RESET;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      write_reg <= 1'b0;
      addr_reg <= BYTE_ZERO;
      wdata_reg <= BYTE_ZERO;
    end else if (state_reg == ST_IDLE && req_valid) begin
      write_reg <= req_write;
      addr_reg <= req_addr;
      wdata_reg <= req_wdata;
    end
  end

  // Read data taken on the last low cycle, before the strobe rises
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      resp_valid <= 1'b0;
      resp_rdata <= BYTE_ZERO;
    end else begin
      resp_valid <= 1'b0;
      if (state_reg == ST_ACC_LOW && cnt_done) begin
        resp_valid <= 1'b1;
        if (!write_reg) begin
          resp_rdata <= data_s;
        end
      end
    end
  end

  logic ptr_phase, acc_phase;
  assign ptr_phase = state_reg == ST_PTR_LOW;
  assign acc_phase = state_reg == ST_ACC_LOW;

  assign req_ready = state_reg == ST_IDLE;
  assign irq_level = irq_s;
  assign bus.reset_in_low = state_reg != ST_RESET;
  assign bus.role_pin = role_strap;
  // Chip select may stay low when the device is alone on the bus
  assign bus.chip_sel_low = keep_cs_low ? 1'b0 : !(ptr_phase || acc_phase); // (R8)
  assign bus.write_strobe_low = !(ptr_phase || (acc_phase && write_reg));
  assign bus.read_strobe_low = !(acc_phase && !write_reg);
  // Selector decoded from state; a multiplexed bus needs an external latch here
  assign bus.pointer_or_data_select = acc_phase || state_reg == ST_PTR_GAP; // (R17)
  // Pointer byte stays on the bus through its gap, or the hold after release is lost
  assign bus.host_data_out = (ptr_phase || state_reg == ST_PTR_GAP) ? addr_reg : wdata_reg;
  // Keep driving through the gap so data holds past the rising edge
  assign bus.host_data_oe_low = !(ptr_phase || state_reg == ST_PTR_GAP ||
                                  (write_reg && (acc_phase || state_reg == ST_ACC_GAP)));
endmodule // hostport_host

// ==== hostport_chk.sv ====
module hostport_chk import hostport_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Processor port
  input wire logic chip_sel_low,
  input wire logic read_strobe_low,
  input wire logic write_strobe_low,
  input wire logic pointer_or_data_select,
  input wire logic reset_in_low,
  input wire logic irq_out,
  input wire logic [7:0] host_data_out,
  input wire logic host_data_oe_low,
  input wire logic dev_data_oe_low
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] low_cnt;
  logic [4:0] quiet_cnt;
  logic [3:0] clr_age;
  logic wr_q;
  logic cs_q;
  logic sel_q;
  logic data_wr_done;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  // Selector is taken from the cycle before the strobe rose, as it may move with it
  assign data_wr_done = write_strobe_low && !wr_q && !cs_q && sel_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_q <= 1'b1;
      cs_q <= 1'b1;
      sel_q <= 1'b0;
    end else begin
      wr_q <= write_strobe_low;
      cs_q <= chip_sel_low;
      sel_q <= pointer_or_data_select;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      low_cnt <= 5'h00;
    end else if (reset_in_low) begin
      low_cnt <= 5'h00;
    end else if (low_cnt != 5'h1F) begin
      low_cnt <= low_cnt + 5'h01;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      quiet_cnt <= 5'h00;
    end else if (!reset_in_low) begin
      quiet_cnt <= 5'h00;
    end else if (quiet_cnt != 5'h1F) begin
      quiet_cnt <= quiet_cnt + 5'h01;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      clr_age <= 4'h0;
    end else if (data_wr_done || !reset_in_low) begin
      clr_age <= 4'h0;
    end else if (clr_age != 4'hF) begin
      clr_age <= clr_age + 4'h1;
    end
  end

  sequence wr_release;
    !write_strobe_low ##1 write_strobe_low;
  endsequence

  drive_gate_a: assert property (!dev_data_oe_low |-> !chip_sel_low && !read_strobe_low)
    else $error("data bus driven outside a read");
  drive_read_a: assert property (!chip_sel_low && !read_strobe_low |-> !dev_data_oe_low)
    else $error("selected read not driven");
  bus_clash_a: assert property (host_data_oe_low || dev_data_oe_low)
    else $error("both ends drive the data bus");
  strobe_cs_a: assert property (!read_strobe_low || !write_strobe_low |-> !chip_sel_low)
    else $error("strobe without chip select");
  data_hold_a: assert property (wr_release |-> $stable(host_data_out))
    else $error("write data moved at strobe release");
  sel_hold_a: assert property (!write_strobe_low |=> write_strobe_low || $stable(pointer_or_data_select))
    else $error("selector moved during write");
  rst_hold_a: assert property ($rose(reset_in_low) |-> low_cnt >= 5'(RESET_HOLD_CLKS))
    else $error("device reset too short");
  quiet_wait_a: assert property (!write_strobe_low || !read_strobe_low |-> quiet_cnt >= 5'(RESET_QUIET_CLKS))
    else $error("access too soon after reset");
  irq_clear_a: assert property ($fell(irq_out) |-> clr_age < 4'h8)
    else $error("interrupt dropped without a clearing write");
endmodule // hostport_chk

// ==== indexed_host_bus_port_tb_top.sv ====
module indexed_host_bus_port_tb_top import hostport_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock;
  logic rst;
  logic req_valid;
  logic req_write;
  logic [7:0] req_addr;
  logic [7:0] req_wdata;
  logic keep_cs_low;
  logic role_strap;
  logic req_ready;
  logic resp_valid;
  logic [7:0] resp_rdata;
  logic irq_level;
  logic [7:0] event_in;
  logic role_peripheral;
  logic in_reset;
  int error_cnt;
  int checked;

  hostport_if bus_if ();
  hostport_host i_hostport_host (.clock(clock), .rst(rst), .bus(bus_if), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .keep_cs_low(keep_cs_low),
    .role_strap(role_strap), .req_ready(req_ready), .resp_valid(resp_valid),
    .resp_rdata(resp_rdata), .irq_level(irq_level));
  hostport_device i_hostport_device (.clock(clock), .rst(rst), .bus(bus_if),
    .event_in(event_in), .role_peripheral(role_peripheral), .in_reset(in_reset));
  hostport_chk i_hostport_chk (.clock(clock), .rst(rst), .chip_sel_low(bus_if.chip_sel_low),
    .read_strobe_low(bus_if.read_strobe_low), .write_strobe_low(bus_if.write_strobe_low),
    .pointer_or_data_select(bus_if.pointer_or_data_select), .reset_in_low(bus_if.reset_in_low),
    .irq_out(bus_if.irq_out), .host_data_out(bus_if.host_data_out),
    .host_data_oe_low(bus_if.host_data_oe_low), .dev_data_oe_low(bus_if.dev_data_oe_low));

  initial clock = 1'b0;
  always #(CLK_PERIOD_NS / 2.0) clock = ~clock;

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Bounded wait; running out is a mismatch and ends the run
  task automatic wait_lvl(ref logic sig, input logic lvl, input string what);
    int n;
    n = 0;
    while (sig !== lvl && n < 500) begin
      @(negedge clock);
      n++;
    end
    check(what, {7'h00, lvl}, {7'h00, sig});
    if (n == 500) print_verdict();
  endtask

  task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wdata);
    wait_lvl(req_ready, 1'b1, "req_ready");
    req_valid = 1'b1;
    req_write = wr;
    req_addr = addr;
    req_wdata = wdata;
    @(negedge clock);
    req_valid = 1'b0;
    wait_lvl(resp_valid, 1'b1, "resp_valid");
    // Let the gap pass: the device acts on a write a few clocks after release
    wait_lvl(req_ready, 1'b1, "req_ready");
  endtask

  task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
    access(1'b0, addr, 8'h00);
    check("read data", exp, resp_rdata);
  endtask

  initial begin
    rst = 1'b1;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = 8'h00;
    req_wdata = 8'h00;
    keep_cs_low = 1'b0;
    role_strap = 1'b1;
    event_in = 8'h00;
    error_cnt = 0;
    checked = 0;
    repeat (20) @(negedge clock);
    rst = 1'b0;
    access(1'b1, 8'h20, 8'hA5);
    check("in reset", 8'h00, {7'h00, in_reset});
    // Pin moves after the sampling point and must be ignored
    role_strap = 1'b0;
    access(1'b1, 8'h21, 8'h5A);
    check("role", 8'h01, {7'h00, role_peripheral});
    rd(8'h20, 8'hA5);
    rd(8'h21, 8'h5A);
    access(1'b1, 8'h20, 8'hC3);
    rd(8'h21, 8'h5A);
    access(1'b1, ROLE_ADDR, 8'h00);
    check("role", 8'h00, {7'h00, role_peripheral});
    access(1'b1, ROLE_ADDR, 8'h01);
    check("role", 8'h01, {7'h00, role_peripheral});
    rd(ROLE_ADDR, 8'h01);
    access(1'b1, IRQ_ENABLE_ADDR, 8'hFF);
    event_in = 8'h01;
    @(negedge clock);
    event_in = 8'h00;
    wait_lvl(irq_level, 1'b1, "irq raised");
    rd(8'h20, 8'hC3);
    check("irq held", 8'h01, {7'h00, irq_level});
    rd(IRQ_STATUS_ADDR, 8'h01);
    rd(IRQ_ENABLE_ADDR, 8'hFF);
    access(1'b1, IRQ_STATUS_ADDR, 8'h01);
    wait_lvl(irq_level, 1'b0, "irq cleared");
    keep_cs_low = 1'b1;
    access(1'b1, 8'h30, 8'h96);
    rd(8'h30, 8'h96);
    // Second reset with the pin low: role must follow it
    rst = 1'b1;
    @(negedge clock);
    rst = 1'b0;
    repeat (6) @(negedge clock);
    check("in reset", 8'h01, {7'h00, in_reset});
    access(1'b1, 8'h31, 8'h3C);
    check("role", 8'h00, {7'h00, role_peripheral});
    rd(8'h31, 8'h3C);
    print_verdict();
  end
endmodule // indexed_host_bus_port_tb_top
